// >>> dtc_top.sv
/*
  Single-channel DMA transfer control: register file, activation, bus
  sequencing, finish pin and interrupts. Assumes a bus controller that
  grants the bus and reports external bus activity by level signals.
*/
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ps
module dtc_top (
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  // Register port
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA,
  // Activation sources
  input  wire logic        INT_REQ,
  input  wire logic        CPU_MASKED,
  input  wire logic        EXT_TRANSFER_REQUEST_IN_N,
  // Bus controller
  input  wire logic        BUS_GRANT,
  input  wire logic        EXT_BUS_BUSY,
  output logic             BUS_REQ,
  output logic             CYC_VALID,
  output logic      [23:0] CYC_ADDR,
  output logic             CYC_WR,
  // Pins and interrupts
  output logic             TRANSFER_FINISHED_OUT_N,
  output logic             CPU_INT_REQ,
  output logic             FINISH_IRQ,
  output logic             IRQ
);
  logic [dtc_pkg::CTRL_W-1:0] ctrl_r;
  logic [23:0]                src_r;
  logic [23:0]                dst_r;
  logic [15:0]                count_r;
  logic [dtc_pkg::EV_W-1:0]   irqst_r;
  logic [dtc_pkg::EV_W-1:0]   irqmsk_r;
  logic [dtc_pkg::EV_W-1:0]   ev;
  dtc_pkg::dtc_state_type     state_r;
  dtc_pkg::dtc_state_type     state_nxt;
  dtc_pkg::dtc_cyc_type       cyc_nxt;
  logic                       int_pend_r;
  logic                       ext_pend;
  logic                       activate;
  logic                       last_r;
  logic                       finish_pend_r;
  logic                       done;
  logic [23:0]                src_a;
  logic [23:0]                dst_a;
  logic [31:0]                rdata_nxt;

  logic en;
  logic ext_mode;
  assign en       = ctrl_r[dtc_pkg::B_EN];
  assign ext_mode = ctrl_r[dtc_pkg::B_EXT];

  dtc_req u_req (
    .clk       (CLK_SYS),
    .rst       (RST),
    .edge_mode (ctrl_r[dtc_pkg::B_EDGE]),
    .enable    (en && ext_mode),
    .req_n     (EXT_TRANSFER_REQUEST_IN_N),
    .taken     (activate),
    .pending   (ext_pend)
  );

  dtc_addr u_addr (
    .short_mode (ctrl_r[dtc_pkg::B_SHORT]),
    .short_src  (ctrl_r[dtc_pkg::B_SSRC]),
    .src_reg    (src_r),
    .dst_reg    (dst_r),
    .src_addr   (src_a),
    .dst_addr   (dst_a)
  );

  // Internal source pending while enable is low and the CPU is masked, kept for later activation
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST)
      int_pend_r <= 1'b0;
    else if (INT_REQ && !ext_mode)
      int_pend_r <= 1'b1;
    else if (activate || (!en && !CPU_MASKED))
      int_pend_r <= 1'b0;
  end

  // Unmasked CPU takes the request as an ordinary interrupt
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST)
      CPU_INT_REQ <= 1'b0;
    else
      CPU_INT_REQ <= !ext_mode && !en && !CPU_MASKED &&
                     (INT_REQ || int_pend_r);
  end

  // Activation only from idle with enable set; a held internal or level-mode request activates again after each transfer
  always_comb begin
    if (ext_mode)
      activate = state_r == dtc_pkg::ST_IDLE && en && ext_pend;
    else
      activate = state_r == dtc_pkg::ST_IDLE && en && int_pend_r;
  end

  assign done = state_r == dtc_pkg::ST_WRITE && last_r;

  // Request, grant, read, write, then a wait state before the next one
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      dtc_pkg::ST_IDLE:  if (activate) state_nxt = dtc_pkg::ST_BREQ;
      dtc_pkg::ST_BREQ:  if (BUS_GRANT) state_nxt = dtc_pkg::ST_READ;
      dtc_pkg::ST_READ:  state_nxt = dtc_pkg::ST_WRITE;
      dtc_pkg::ST_WRITE: state_nxt = dtc_pkg::ST_WAIT;
      dtc_pkg::ST_WAIT:  state_nxt = dtc_pkg::ST_IDLE;
      default:           state_nxt = dtc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST)
      state_r <= dtc_pkg::ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Bus held only from request to write; released in wait and idle
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST)
      BUS_REQ <= 1'b0;
    else
      BUS_REQ <= state_nxt == dtc_pkg::ST_BREQ ||
                 state_nxt == dtc_pkg::ST_READ ||
                 state_nxt == dtc_pkg::ST_WRITE;
  end

  always_comb begin
    cyc_nxt.addr = src_a;
    cyc_nxt.wr   = 1'b0;
    cyc_nxt.ext  = ctrl_r[dtc_pkg::B_SEXT];
    if (state_nxt == dtc_pkg::ST_WRITE) begin
      cyc_nxt.addr = dst_a;
      cyc_nxt.wr   = 1'b1;
      cyc_nxt.ext  = ctrl_r[dtc_pkg::B_DEXT];
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      CYC_VALID <= 1'b0;
      CYC_ADDR  <= '0;
      CYC_WR    <= 1'b0;
    end else begin
      CYC_VALID <= state_nxt == dtc_pkg::ST_READ ||
                   state_nxt == dtc_pkg::ST_WRITE;
      CYC_ADDR  <= cyc_nxt.addr;
      CYC_WR    <= cyc_nxt.wr;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST)
      last_r <= 1'b0;
    else if (activate)
      last_r <= count_r == dtc_pkg::COUNT_ONE;
  end

  // Internal-only transfer: finish held until the external bus is idle
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST)
      finish_pend_r <= 1'b0;
    else if (state_nxt == dtc_pkg::ST_READ && last_r &&
             !ctrl_r[dtc_pkg::B_SEXT] && !ctrl_r[dtc_pkg::B_DEXT])
      finish_pend_r <= 1'b1;
    else if (!EXT_BUS_BUSY)
      finish_pend_r <= 1'b0;
  end

  // Low in the final transfer's external cycles; an internal-only transfer shows it once the bus is idle
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST)
      TRANSFER_FINISHED_OUT_N <= 1'b1;
    else if ((ctrl_r[dtc_pkg::B_SEXT] || ctrl_r[dtc_pkg::B_DEXT]) && last_r)
      TRANSFER_FINISHED_OUT_N <= !(cyc_nxt.ext &&
        (state_nxt == dtc_pkg::ST_READ ||
         state_nxt == dtc_pkg::ST_WRITE));
    else
      TRANSFER_FINISHED_OUT_N <= !(finish_pend_r && !EXT_BUS_BUSY);
  end

  // Register writes; finishing clears enable, and hardware wins the race
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ctrl_r  <= '0;
      src_r   <= '0;
      dst_r   <= '0;
      count_r <= dtc_pkg::COUNT_ZERO;
    end else begin
      if (REG_WR && REG_ADDR == dtc_pkg::OFF_CTRL)
        ctrl_r <= REG_WDATA[dtc_pkg::CTRL_W-1:0];
      if (REG_WR && REG_ADDR == dtc_pkg::OFF_SRC)
        src_r <= REG_WDATA[23:0];
      if (REG_WR && REG_ADDR == dtc_pkg::OFF_DST)
        dst_r <= REG_WDATA[23:0];
      if (REG_WR && REG_ADDR == dtc_pkg::OFF_COUNT)
        count_r <= REG_WDATA[15:0];
      if (state_r == dtc_pkg::ST_WRITE) begin
        src_r   <= src_r + 24'h000001;
        dst_r   <= dst_r + 24'h000001;
        count_r <= count_r - dtc_pkg::COUNT_ONE;
      end
      if (done)
        ctrl_r[dtc_pkg::B_EN] <= 1'b0;
    end
  end

  // Level request repeats while end-irq enable set and channel disabled
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST)
      FINISH_IRQ <= 1'b0;
    else
      FINISH_IRQ <= ctrl_r[dtc_pkg::B_IE] && !ctrl_r[dtc_pkg::B_EN];
  end

  assign ev = {state_r == dtc_pkg::ST_WRITE, CPU_INT_REQ, done};

  // Sticky status, write one to clear, a new event wins over the clear
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      irqst_r  <= '0;
      irqmsk_r <= '0;
    end else begin
      if (REG_WR && REG_ADDR == dtc_pkg::OFF_IRQMSK)
        irqmsk_r <= REG_WDATA[dtc_pkg::EV_W-1:0];
      if (REG_WR && REG_ADDR == dtc_pkg::OFF_IRQST)
        irqst_r <= (irqst_r & ~REG_WDATA[dtc_pkg::EV_W-1:0]) | ev;
      else
        irqst_r <= irqst_r | ev;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST)
      IRQ <= 1'b0;
    else
      IRQ <= |(irqst_r & irqmsk_r);
  end

  always_comb begin
    rdata_nxt = '0;
    unique case (REG_ADDR)
      dtc_pkg::OFF_CTRL:   rdata_nxt[dtc_pkg::CTRL_W-1:0] = ctrl_r;
      dtc_pkg::OFF_SRC:    rdata_nxt[23:0] = src_r;
      dtc_pkg::OFF_DST:    rdata_nxt[23:0] = dst_r;
      dtc_pkg::OFF_COUNT:  rdata_nxt[15:0] = count_r;
      dtc_pkg::OFF_STATUS: rdata_nxt[4:0]  = state_r;
      dtc_pkg::OFF_IRQST:  rdata_nxt[dtc_pkg::EV_W-1:0] = irqst_r;
      dtc_pkg::OFF_IRQMSK: rdata_nxt[dtc_pkg::EV_W-1:0] = irqmsk_r;
      default:             rdata_nxt = '0;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST)
      REG_RDATA <= '0;
    else
      REG_RDATA <= REG_RD ? rdata_nxt : '0;
  end
endmodule : dtc_top

// >>> dtc_pkg.sv
/*
  Shared constants and carrier types of the single-channel DMA transfer
  control block: register offsets, field positions, reset values, states.
  Assumes a single system clock and a plain strobe register port.
*/
package dtc_pkg;
  localparam int AW = 4;
  localparam int DW = 32;
  localparam logic [AW-1:0] OFF_CTRL   = 4'h0;
  localparam logic [AW-1:0] OFF_SRC    = 4'h1;
  localparam logic [AW-1:0] OFF_DST    = 4'h2;
  localparam logic [AW-1:0] OFF_COUNT  = 4'h3;
  localparam logic [AW-1:0] OFF_STATUS = 4'h4;
  localparam logic [AW-1:0] OFF_IRQST  = 4'h5;
  localparam logic [AW-1:0] OFF_IRQMSK = 4'h6;
  // Control register bit positions
  localparam int B_EN    = 0;
  localparam int B_IE    = 1;
  localparam int B_SHORT = 2;
  localparam int B_SSRC  = 3;
  localparam int B_EXT   = 4;
  localparam int B_EDGE  = 5;
  localparam int B_SEXT  = 6;
  localparam int B_DEXT  = 7;
  localparam int CTRL_W  = 8;
  // Event status bit positions
  localparam int E_DONE = 0;
  localparam int E_CPU  = 1;
  localparam int E_XFER = 2;
  localparam int EV_W   = 3;
  localparam logic [7:0]  SHORT_TOP  = 8'hff;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_ONE  = 16'h0001;
  localparam int GAP_STATES = 2;
  typedef struct packed {
    logic [23:0] addr;
    logic        wr;
    logic        ext;
  } dtc_cyc_type;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_BREQ  = 5'h02,
    ST_READ  = 5'h04,
    ST_WRITE = 5'h08,
    ST_WAIT  = 5'h10
  } dtc_state_type;
endpackage : dtc_pkg

// >>> dtc_req.sv
/*
  External request detector: level or falling-edge sensing with first
  activation on a low level. Assumes the pin is synchronous to the clock.
*/
`timescale 1ns/1ps
module dtc_req (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Mode and pin
  input  wire logic edge_mode,
  input  wire logic enable,
  input  wire logic req_n,
  input  wire logic taken,
  // Held activation
  output logic      pending
);
  logic req_d_r;
  logic first_r;
  logic pending_r;
  logic hit;

  always_comb begin
    if (!edge_mode)
      hit = !req_n;
    else if (first_r)
      hit = !req_n;
    else
      hit = req_d_r && !req_n;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      req_d_r <= 1'b1;
    else
      req_d_r <= req_n;
  end

  // Rearm level detection whenever the channel is disabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      first_r <= 1'b1;
    else if (!enable)
      first_r <= 1'b1;
    else if (hit)
      first_r <= 1'b0;
  end

  // Once latched the request is held until served or the channel is disabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      pending_r <= 1'b0;
    else if (!enable)
      pending_r <= 1'b0;
    else if (hit)
      pending_r <= 1'b1;
    else if (taken)
      pending_r <= 1'b0;
  end

  assign pending = pending_r;
endmodule : dtc_req

// >>> dtc_addr.sv
/*
  Address former: full address mode, or short address mode for either source or destination.
  Assumes the register values are stable during a transfer.
*/
`timescale 1ns/1ps
module dtc_addr (
  input  wire logic        short_mode,
  input  wire logic        short_src,
  input  wire logic [23:0] src_reg,
  input  wire logic [23:0] dst_reg,
  output logic      [23:0] src_addr,
  output logic      [23:0] dst_addr
);
  function automatic logic [23:0] widen(input logic [23:0] a,
                                        input logic        s);
    widen = s ? {dtc_pkg::SHORT_TOP, a[15:0]} : a;
  endfunction : widen

  assign src_addr = widen(src_reg, short_mode && short_src);
  assign dst_addr = widen(dst_reg, short_mode && !short_src);
endmodule : dtc_addr

// >>> dtc_props.sv
/*
  Port checker for dtc_top: bus sequencing, finish pin, read port.
  Assumes it is bound to dtc_top with one clock and RST high active.
*/
`timescale 1ns/1ps
module dtc_props (
  // Clock and reset
  input wire logic        CLK_SYS,
  input wire logic        RST,
  // Watched ports
  input wire logic        REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic        INT_REQ,
  input wire logic        CPU_MASKED,
  input wire logic        BUS_GRANT,
  input wire logic        EXT_BUS_BUSY,
  input wire logic        BUS_REQ,
  input wire logic        CYC_VALID,
  input wire logic        CYC_WR,
  input wire logic        TRANSFER_FINISHED_OUT_N,
  input wire logic        CPU_INT_REQ
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  AST_GAP: assert property ($fell(BUS_REQ) |-> !BUS_REQ ##1 !BUS_REQ)
    else $error("transfers closer than two states");
  AST_REQ_HOLD: assert property (BUS_REQ && !BUS_GRANT |=> BUS_REQ)
    else $error("bus request dropped before grant");
  AST_CYC_GRANT: assert property ($rose(CYC_VALID) |->
    $past(BUS_GRANT) && BUS_REQ) else $error("cycle without grant");
  AST_PAIR: assert property (CYC_VALID && !CYC_WR |=>
    CYC_VALID && CYC_WR) else $error("read not followed by write");
  AST_RELEASE: assert property (CYC_VALID && CYC_WR |=>
    !BUS_REQ && !CYC_VALID) else $error("bus kept after write");
  AST_FIN_SHORT: assert property ($fell(TRANSFER_FINISHED_OUT_N) |->
    ##[1:2] TRANSFER_FINISHED_OUT_N) else $error("finish pin held low");
  AST_FIN_IDLE: assert property (!TRANSFER_FINISHED_OUT_N && !CYC_VALID
    |-> !$past(EXT_BUS_BUSY)) else $error("finish pin while bus busy");
  AST_RDATA: assert property (REG_RDATA != 32'h0 |-> $past(REG_RD))
    else $error("read data outside read slot");
  AST_CPU_INT: assert property ($rose(CPU_INT_REQ) |->
    $past(INT_REQ) && !$past(CPU_MASKED)) else $error("bad CPU request");

  cover property (CYC_VALID && CYC_WR);
  cover property (!TRANSFER_FINISHED_OUT_N && !CYC_VALID);
  cover property ($rose(CPU_INT_REQ));
endmodule : dtc_props

// >>> dtc_bus_model.sv
/*
  Bus controller and external bus model facing dtc_top.
  Assumes one clock; the bench sets the external busy level.
*/
`timescale 1ns/1ps
module dtc_bus_model #(
  parameter int GRANT_DLY = 2
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Device side
  input  wire logic        bus_req,
  input  wire logic        cyc_valid,
  input  wire logic [23:0] cyc_addr,
  input  wire logic        cyc_wr,
  input  wire logic        fin_n,
  input  wire logic        busy_cmd,
  output logic             bus_grant,
  output logic             ext_bus_busy,
  // Observations
  output logic      [23:0] rd_addr,
  output logic      [23:0] wr_addr,
  output int               xfers,
  output int               fin_cnt
);
  int wait_cnt;
  // Refresh or buffered write keeps the bus busy as the bench commands
  assign ext_bus_busy = busy_cmd;
  // Slow arbitration; grant is withdrawn at the first clock that sees the request low, one cycle after it drops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_cnt  <= 0;
      bus_grant <= 1'b0;
    end else begin
      wait_cnt  <= bus_req ? wait_cnt + 1 : 0;
      bus_grant <= bus_req && (wait_cnt >= GRANT_DLY);
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xfers   <= 0;
      fin_cnt <= 0;
      rd_addr <= 24'h0;
      wr_addr <= 24'h0;
    end else begin
      if (cyc_valid && !cyc_wr)
        rd_addr <= cyc_addr;
      if (cyc_valid && cyc_wr) begin
        wr_addr <= cyc_addr;
        xfers   <= xfers + 1;
      end
      if (!fin_n)
        fin_cnt <= fin_cnt + 1;
    end
  end
endmodule : dtc_bus_model

// >>> testbench.sv
/*
  Self-checking bench for dtc_top with the bus model on its far side.
  Assumes dtc_pkg is compiled first.
*/
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        int_req = 1'b0;
  logic        masked = 1'b0;
  logic        req_n = 1'b1;
  logic        busy_cmd = 1'b0;
  logic [31:0] rdata;
  logic        grant, busy, breq, cvalid, cwr, fin_n, cpu_int, fin_irq;
  logic        irq, irq_a;
  logic [23:0] caddr, rd_addr, wr_addr;
  int          xfers, fin_cnt;
  int          bad_count = 0;
  int          comparisons = 0;

  always #50 clk = ~clk;

  dtc_top dtc_top_i (.CLK_SYS(clk), .RST(rst), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .INT_REQ(int_req), .CPU_MASKED(masked),
    .EXT_TRANSFER_REQUEST_IN_N(req_n), .BUS_GRANT(grant),
    .EXT_BUS_BUSY(busy), .BUS_REQ(breq), .CYC_VALID(cvalid),
    .CYC_ADDR(caddr), .CYC_WR(cwr), .TRANSFER_FINISHED_OUT_N(fin_n),
    .CPU_INT_REQ(cpu_int), .FINISH_IRQ(fin_irq), .IRQ(irq));
  dtc_bus_model dtc_bus_model_i (.clk(clk), .rst(rst), .bus_req(breq),
    .cyc_valid(cvalid), .cyc_addr(caddr), .cyc_wr(cwr), .fin_n(fin_n),
    .busy_cmd(busy_cmd), .bus_grant(grant), .ext_bus_busy(busy),
    .rd_addr(rd_addr), .wr_addr(wr_addr), .xfers(xfers),
    .fin_cnt(fin_cnt));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    if (bad_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    check(rdata, exp);
  endtask : rd_reg
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle
  // Bounded wait on the model's transfer count; a hang ends the run
  task automatic wait_x(input int n);
    int i;
    for (i = 0; i < 300 && xfers != n; i++) @(posedge clk);
    if (xfers != n) begin
      check(xfers, n);
      summarize();
    end
  endtask : wait_x

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    idle(1);
    check(fin_n, 1'b1);
    rd_reg(4'hf, 32'h0);
    rd_reg(dtc_pkg::OFF_CTRL, 32'h0);
    // Two external-to-external transfers on internal activation
    wr_reg(dtc_pkg::OFF_SRC, 32'h100);
    wr_reg(dtc_pkg::OFF_DST, 32'h1200);
    wr_reg(dtc_pkg::OFF_COUNT, 32'h2);
    int_req <= 1'b1;
    wr_reg(dtc_pkg::OFF_CTRL, 32'hc3);
    wait_x(2);
    idle(6);
    check(rd_addr, 24'h000101);
    check(wr_addr, 24'h001201);
    check(fin_cnt, 2);
    check(fin_irq, 1'b1);
    check(cpu_int, 1'b1);
    check(xfers, 2);
    rd_reg(dtc_pkg::OFF_COUNT, 32'h0);
    rd_reg(dtc_pkg::OFF_CTRL, 32'hc2);
    wr_reg(dtc_pkg::OFF_CTRL, 32'hc0);
    idle(2);
    check(fin_irq, 1'b0);
    @(posedge clk);
    int_req <= 1'b0;
    // Mask polarity is the designer's; both settings must differ
    wr_reg(dtc_pkg::OFF_IRQMSK, 32'h0);
    idle(2);
    irq_a = irq;
    wr_reg(dtc_pkg::OFF_IRQMSK, 32'h7);
    idle(2);
    check(irq ^ irq_a, 1'b1);
    wr_reg(dtc_pkg::OFF_IRQST, 32'h7);
    rd_reg(dtc_pkg::OFF_IRQST, 32'h0);
    check(irq, 1'b0);
    // Masked pending request, short source, internal addresses
    @(posedge clk);
    masked   <= 1'b1;
    int_req  <= 1'b1;
    busy_cmd <= 1'b1;
    wr_reg(dtc_pkg::OFF_SRC, 32'h123456);
    wr_reg(dtc_pkg::OFF_DST, 32'habcd);
    wr_reg(dtc_pkg::OFF_COUNT, 32'h1);
    idle(1);
    check(cpu_int, 1'b0);
    wr_reg(dtc_pkg::OFF_CTRL, 32'h0d);
    wait_x(3);
    idle(6);
    check(rd_addr, 24'hff3456);
    check(wr_addr, 24'h00abcd);
    check(fin_cnt, 2);
    @(posedge clk);
    busy_cmd <= 1'b0;
    idle(4);
    check(fin_cnt, 3);
    // Unmask first so the held request reaches the CPU while still raised
    @(posedge clk);
    masked  <= 1'b0;
    @(posedge clk);
    int_req <= 1'b0;
    // Edge mode, short destination: pin already low when enabled
    req_n <= 1'b0;
    wr_reg(dtc_pkg::OFF_COUNT, 32'h2);
    wr_reg(dtc_pkg::OFF_CTRL, 32'h35);
    wait_x(4);
    idle(20);
    check(xfers, 4);
    check(rd_addr, 24'h123457);
    check(wr_addr, 24'hffabce);
    @(posedge clk);
    req_n <= 1'b1;
    idle(2);
    @(posedge clk);
    req_n <= 1'b0;
    wait_x(5);
    idle(4);
    check(xfers, 5);
    // Level mode: two-state pulse is kept
    @(posedge clk);
    req_n <= 1'b1;
    wr_reg(dtc_pkg::OFF_COUNT, 32'h1);
    wr_reg(dtc_pkg::OFF_CTRL, 32'h11);
    req_n <= 1'b0;
    idle(2);
    @(posedge clk);
    req_n <= 1'b1;
    wait_x(6);
    idle(4);
    check(xfers, 6);
    summarize();
  end
endmodule : testbench

bind dtc_top dtc_props dtc_props_i (.CLK_SYS(CLK_SYS), .RST(RST),
  .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .INT_REQ(INT_REQ),
  .CPU_MASKED(CPU_MASKED), .BUS_GRANT(BUS_GRANT),
  .EXT_BUS_BUSY(EXT_BUS_BUSY), .BUS_REQ(BUS_REQ), .CYC_VALID(CYC_VALID),
  .CYC_WR(CYC_WR), .TRANSFER_FINISHED_OUT_N(TRANSFER_FINISHED_OUT_N),
  .CPU_INT_REQ(CPU_INT_REQ));
